// *** src/uet_pkg.sv ***
// Package for the endpoint tag, transceiver control and auto-resume block.
// Assumes a 32-bit classic Wishbone slave port and one 200 MHz core clock.
package uet_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_EP_TAG_MASK = 8'h34;
    localparam logic [7:0] OFF_OTG_FLAG_MASK = 8'h38;
    localparam logic [7:0] OFF_POWER_SIGNAL = 8'h3C;
    localparam logic [7:0] OFF_XCVR_CTRL = 8'h40;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h44;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h48;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h4C;

    // Reset values
    localparam logic [15:0] RST_EP_TAG_MASK = 16'h0000;
    localparam logic [31:0] RST_OTG_FLAG_MASK = 32'h0000_0000;
    localparam logic [8:0] RST_POWER_SIGNAL = 9'h000;
    localparam logic [31:0] RST_XCVR_CTRL = 32'h0000_0000;
    localparam logic [1:0] RST_IRQ = 2'h0;

    // Writable bits of the tag, power and transceiver control registers
    localparam logic [31:0] WMASK_EP_TAG = 32'h0000_FFFF;
    localparam logic [31:0] WMASK_POWER = 32'h0000_01FF;
    localparam logic [31:0] WMASK_XCVR_CTRL = 32'h0004_0FF0;

    // Transceiver control field positions
    localparam int XC_PD_DIS = 18;
    localparam int XC_FLAG_SE0 = 13;
    localparam int XC_FLAG_K = 12;
    localparam int XC_FILT_LSB = 8;
    localparam int XC_FILT_MSB = 11;
    localparam int XC_AUTO_RES = 7;
    localparam int XC_CONF_LSB = 4;
    localparam int XC_CONF_MSB = 6;

    // Interrupt status bit positions
    localparam int IRQ_SE0 = 0;
    localparam int IRQ_K = 1;

    // Endpoint tag value ORed into a marked endpoint number
    localparam logic [4:0] EP_TAG_BIT = 5'h10;

    // Line states, {D-, D+}
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_K = 2'h2;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } uet_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } uet_wb_rsp_s;

    typedef struct packed {
        logic valid;
        logic [3:0] ep;
    } uet_rx_ep_s;

    typedef struct packed {
        logic valid;
        logic [4:0] ep;
    } uet_rx_tag_s;

    typedef enum logic {
        UET_AWAKE,
        UET_SUSPENDED
    } uet_susp_e;

endpackage

// *** src/uet_ls_filter.sv ***
// Line-state glitch filter: a new state passes once it has held steady
// for two to the power of the programmed exponent clocks.
// Assumes its input is already synchronised to the core clock.
module uet_ls_filter (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [1:0] i_ls,
    input wire logic [3:0] i_log2,
    output logic [1:0] o_ls
);
    logic [1:0] cand_q;
    logic [15:0] cnt_q;
    logic [16:0] limit;
    logic [16:0] cnt_next;

    assign limit = 17'h00001 << i_log2;
    assign cnt_next = {1'b0, cnt_q} + 17'h00001;

    // Any change of the candidate restarts the count, so glitches die here
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cand_q <= 2'h0;
            cnt_q <= 16'h0000;
            o_ls <= 2'h0;
        end else if (i_ls != cand_q) begin
            cand_q <= i_ls;
            cnt_q <= 16'h0000;
        end else if (cand_q != o_ls) begin
            if (cnt_next >= limit) begin
                o_ls <= cand_q;
                cnt_q <= 16'h0000;
            end else begin
                cnt_q <= cnt_next[15:0];
            end
        end
    end
endmodule // uet_ls_filter

// *** src/uet_top.sv ***
// Endpoint tagging, transceiver pin control and suspend auto-resume.
// Assumes a classic Wishbone master and a line state from the pins.
//
// Implementation choice: the Wishbone slave port.
module uet_top (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire uet_pkg::uet_wb_req_s i_wb,
    output uet_pkg::uet_wb_rsp_s o_wb,
    input wire uet_pkg::uet_rx_ep_s i_rx_ep,
    output uet_pkg::uet_rx_tag_s o_rx_ep,
    input wire logic [1:0] i_line_state,
    output logic [1:0] o_line_state_filt,
    input wire logic i_suspend_req,
    input wire logic i_wake_req,
    output logic o_suspended,
    output logic o_resume_pulse,
    output logic o_eight_bit_port_a_pd_dis,
    output logic o_eight_bit_port_b_pd_dis,
    output logic [2:0] o_transceiver_config_pins,
    output logic o_irq
);
    logic [15:0] ep_mask_q;
    logic [31:0] otg_mask_q;
    logic [8:0] power_q;
    logic [31:0] ctrl_q;
    logic [1:0] irq_sts_q;
    logic [1:0] irq_en_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic [31:0] bmask;
    logic wr_acc;
    logic rd_req;
    logic [1:0] ls_s1_q;
    logic [1:0] ls_s2_q;
    logic [1:0] ls_s3_q;
    logic [1:0] ls_stable_q;
    logic [1:0] ls_filt;
    uet_pkg::uet_susp_e susp_q;
    logic wake_se0;
    logic wake_k;
    logic clr_se0;
    logic clr_k;

    // Write takes effect at the edge where the master samples ack
    assign wr_acc = i_wb.cyc && i_wb.stb && i_wb.we && ack_q;
    assign rd_req = i_wb.cyc && i_wb.stb && !ack_q;
    assign bmask = {{8{i_wb.sel[3]}}, {8{i_wb.sel[2]}},
                    {8{i_wb.sel[1]}}, {8{i_wb.sel[0]}}};

    // Bus slave: ack one cycle after the request is seen, then drop
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= i_wb.cyc && i_wb.stb && !ack_q;
        end
    end

    always_comb begin
        rdat_d = 32'h0000_0000;
        unique case (i_wb.adr)
            uet_pkg::OFF_EP_TAG_MASK: rdat_d = {16'h0000, ep_mask_q};
            uet_pkg::OFF_OTG_FLAG_MASK: rdat_d = otg_mask_q;
            uet_pkg::OFF_POWER_SIGNAL: rdat_d = {23'h000000, power_q};
            uet_pkg::OFF_XCVR_CTRL: rdat_d = ctrl_q;
            uet_pkg::OFF_IRQ_STATUS: rdat_d = {30'h0000_0000, irq_sts_q};
            uet_pkg::OFF_IRQ_ENABLE: rdat_d = {30'h0000_0000, irq_en_q};
            default: rdat_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdat_q <= 32'h0000_0000;
        end else if (rd_req && !i_wb.we) begin
            rdat_q <= rdat_d;
        end else if (rd_req) begin
            rdat_q <= 32'h0000_0000;
        end
    end

    assign o_wb.ack = ack_q;
    assign o_wb.dat = rdat_q;

    // Plain storage registers
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ep_mask_q <= uet_pkg::RST_EP_TAG_MASK;
            otg_mask_q <= uet_pkg::RST_OTG_FLAG_MASK;
            power_q <= uet_pkg::RST_POWER_SIGNAL;
            irq_en_q <= uet_pkg::RST_IRQ;
        end else if (wr_acc) begin
            unique case (i_wb.adr)
                uet_pkg::OFF_EP_TAG_MASK: begin
                    ep_mask_q <= (ep_mask_q & ~bmask[15:0])
                                 | (i_wb.dat[15:0] & bmask[15:0]);
                end
                uet_pkg::OFF_OTG_FLAG_MASK: begin
                    otg_mask_q <= (otg_mask_q & ~bmask)
                                  | (i_wb.dat & bmask);
                end
                uet_pkg::OFF_POWER_SIGNAL: begin
                    power_q <= (power_q & ~bmask[8:0])
                               | (i_wb.dat[8:0] & bmask[8:0]);
                end
                uet_pkg::OFF_IRQ_ENABLE: begin
                    if (i_wb.sel[0]) begin
                        irq_en_q <= i_wb.dat[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Endpoint tagging on the receive port
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_ep <= '0;
        end else begin
            o_rx_ep.valid <= i_rx_ep.valid;
            if (i_rx_ep.valid) begin
                o_rx_ep.ep <= ep_mask_q[i_rx_ep.ep]
                    ? ({1'b0, i_rx_ep.ep} | uet_pkg::EP_TAG_BIT)
                    : {1'b0, i_rx_ep.ep};
            end
        end
    end

    // Pin line state: three flops, accepted once second and third agree
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ls_s1_q <= 2'h0;
            ls_s2_q <= 2'h0;
            ls_s3_q <= 2'h0;
            ls_stable_q <= 2'h0;
        end else begin
            ls_s1_q <= i_line_state;
            ls_s2_q <= ls_s1_q;
            ls_s3_q <= ls_s2_q;
            if (ls_s2_q == ls_s3_q) begin
                ls_stable_q <= ls_s3_q;
            end
        end
    end

    uet_ls_filter u_ls_filter (
        .i_core_clk (i_core_clk),
        .i_rst_n (i_rst_n),
        .i_ls (ls_stable_q),
        .i_log2 (ctrl_q[uet_pkg::XC_FILT_MSB:uet_pkg::XC_FILT_LSB]),
        .o_ls (ls_filt)
    );

    // Software polls this copy when auto-resume is off
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_line_state_filt <= 2'h0;
        end else begin
            o_line_state_filt <= ls_filt;
        end
    end

    // Suspend controller: wakes itself only when auto-resume is enabled
    assign wake_se0 = (susp_q == uet_pkg::UET_SUSPENDED)
                      && ctrl_q[uet_pkg::XC_AUTO_RES]
                      && (ls_filt == uet_pkg::LS_SE0);
    assign wake_k = (susp_q == uet_pkg::UET_SUSPENDED)
                    && ctrl_q[uet_pkg::XC_AUTO_RES]
                    && (ls_filt == uet_pkg::LS_K);

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            susp_q <= uet_pkg::UET_AWAKE;
            o_resume_pulse <= 1'b0;
        end else begin
            o_resume_pulse <= 1'b0;
            unique case (susp_q)
                uet_pkg::UET_AWAKE: begin
                    if (i_suspend_req) begin
                        susp_q <= uet_pkg::UET_SUSPENDED;
                    end
                end
                uet_pkg::UET_SUSPENDED: begin
                    if (wake_se0 || wake_k || i_wake_req) begin
                        susp_q <= uet_pkg::UET_AWAKE;
                        o_resume_pulse <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign o_suspended = (susp_q == uet_pkg::UET_SUSPENDED);

    // Flags clear only on a written zero; a wake in the same cycle wins
    assign clr_se0 = wr_acc && (i_wb.adr == uet_pkg::OFF_XCVR_CTRL)
                     && i_wb.sel[1] && !i_wb.dat[uet_pkg::XC_FLAG_SE0];
    assign clr_k = wr_acc && (i_wb.adr == uet_pkg::OFF_XCVR_CTRL)
                   && i_wb.sel[1] && !i_wb.dat[uet_pkg::XC_FLAG_K];

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_q <= uet_pkg::RST_XCVR_CTRL;
        end else begin
            if (wr_acc && (i_wb.adr == uet_pkg::OFF_XCVR_CTRL)) begin
                // Flag bits are outside this mask and handled below
                ctrl_q[31:14] <= (ctrl_q[31:14]
                    & ~(bmask[31:14] & uet_pkg::WMASK_XCVR_CTRL[31:14]))
                    | (i_wb.dat[31:14] & bmask[31:14]
                    & uet_pkg::WMASK_XCVR_CTRL[31:14]);
                ctrl_q[11:0] <= (ctrl_q[11:0]
                    & ~(bmask[11:0] & uet_pkg::WMASK_XCVR_CTRL[11:0]))
                    | (i_wb.dat[11:0] & bmask[11:0]
                    & uet_pkg::WMASK_XCVR_CTRL[11:0]);
            end
            if (wake_se0) begin
                ctrl_q[uet_pkg::XC_FLAG_SE0] <= 1'b1;
            end else if (clr_se0) begin
                ctrl_q[uet_pkg::XC_FLAG_SE0] <= 1'b0;
            end
            if (wake_k && !wake_se0) begin
                ctrl_q[uet_pkg::XC_FLAG_K] <= 1'b1;
            end else if (clr_k) begin
                ctrl_q[uet_pkg::XC_FLAG_K] <= 1'b0;
            end
        end
    end

    assign o_eight_bit_port_a_pd_dis = ctrl_q[uet_pkg::XC_PD_DIS];
    assign o_eight_bit_port_b_pd_dis = ctrl_q[uet_pkg::XC_PD_DIS];
    assign o_transceiver_config_pins =
        ctrl_q[uet_pkg::XC_CONF_MSB:uet_pkg::XC_CONF_LSB];

    // Interrupt status: sticky, write one to clear, set wins
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_sts_q <= uet_pkg::RST_IRQ;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_acc && (i_wb.adr == uet_pkg::OFF_IRQ_CLEAR)
                    && i_wb.sel[0] && i_wb.dat[i]) begin
                    irq_sts_q[i] <= 1'b0;
                end
            end
            if (wake_se0) begin
                irq_sts_q[uet_pkg::IRQ_SE0] <= 1'b1;
            end
            if (wake_k && !wake_se0) begin
                irq_sts_q[uet_pkg::IRQ_K] <= 1'b1;
            end
        end
    end

    // Registered, so the line trails the status by one cycle
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_sts_q & irq_en_q);
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_ep_tag_or: assert property (
        i_rx_ep.valid |=> o_rx_ep.valid && o_rx_ep.ep ==
            ({$past(ep_mask_q[i_rx_ep.ep]), 4'h0} | {1'b0, $past(i_rx_ep.ep)}))
        else $error("received endpoint tag wrong");

    a_pulldown_both: assert property (
        wr_acc && i_wb.adr == uet_pkg::OFF_XCVR_CTRL && i_wb.sel[2]
        |=> o_eight_bit_port_a_pd_dis == $past(i_wb.dat[uet_pkg::XC_PD_DIS])
            && o_eight_bit_port_b_pd_dis == o_eight_bit_port_a_pd_dis)
        else $error("pulldown disable not following control bit");

    a_se0_flag_set: assert property (
        wake_se0 |=> ctrl_q[uet_pkg::XC_FLAG_SE0] && !o_suspended
            && o_resume_pulse)
        else $error("reset resume flag not set");

    a_k_flag_set: assert property (
        wake_k |=> ctrl_q[uet_pkg::XC_FLAG_K] && !o_suspended)
        else $error("resume flag not set");

    a_k_flag_hold: assert property (
        ctrl_q[uet_pkg::XC_FLAG_K] && !clr_k |=> ctrl_q[uet_pkg::XC_FLAG_K])
        else $error("resume flag dropped without a written zero");

    a_filter_holds: assert property (
        $changed(ls_filt) && ctrl_q[uet_pkg::XC_FILT_MSB:uet_pkg::XC_FILT_LSB]
            != 4'h0 && $stable(ctrl_q)
        |-> $past(ls_stable_q, 1) == ls_filt && $past(ls_stable_q, 2) == ls_filt)
        else $error("line state passed before holding steady");

    a_no_self_wake: assert property (
        o_suspended && !ctrl_q[uet_pkg::XC_AUTO_RES] && !i_wake_req
        |=> o_suspended && !$rose(ctrl_q[uet_pkg::XC_FLAG_SE0])
            && !$rose(ctrl_q[uet_pkg::XC_FLAG_K]))
        else $error("woke without auto-resume enabled");

    a_conf_pins: assert property (
        wr_acc && i_wb.adr == uet_pkg::OFF_XCVR_CTRL && i_wb.sel[0]
        |=> o_transceiver_config_pins == $past(i_wb.dat[6:4]))
        else $error("configuration pins not following write");

    a_reserved_zero: assert property (
        rd_req && !i_wb.we && i_wb.adr == uet_pkg::OFF_XCVR_CTRL
        |=> o_wb.ack && o_wb.dat[31:19] == 13'h0000
            && o_wb.dat[17:14] == 4'h0 && o_wb.dat[3:0] == 4'h0)
        else $error("reserved control bits not zero");

    c_se0_resume: cover property (wake_se0 ##1 o_resume_pulse);
    c_k_resume: cover property (wake_k ##1 o_resume_pulse);
    c_tagged_ep: cover property (o_rx_ep.valid && o_rx_ep.ep[4]);
    c_irq: cover property (o_irq);
endmodule // uet_top

// *** dv/uet_xcvr_model.sv ***
// Transceiver stand-in: drives the line state seen at the block's pins.
// Assumes one core clock; the idle bus rests at J through the pull-up.
module uet_xcvr_model (
    input wire logic i_core_clk,
    output logic [1:0] o_line_state
);
    timeunit 1ns;
    timeprecision 100ps;

    initial o_line_state = 2'h1;

    // Hold a state for n clocks, then release to idle J
    task automatic hold(input logic [1:0] ls, input int n);
        @(posedge i_core_clk);
        o_line_state <= ls;
        repeat (n) @(posedge i_core_clk);
        o_line_state <= 2'h1;
    endtask
endmodule // uet_xcvr_model

// *** dv/uet_top_bench.sv ***
// Self-checking bench for endpoint tagging, pin control and auto-resume.
// Assumes the package, design files and transceiver model compile first.
module uet_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk;
    logic rst_n;
    uet_pkg::uet_wb_req_s wb;
    uet_pkg::uet_wb_rsp_s wb_rsp;
    uet_pkg::uet_rx_ep_s rx;
    uet_pkg::uet_rx_tag_s rx_tag;
    logic [1:0] ls;
    logic [1:0] ls_filt;
    logic susp_req;
    logic wake_req;
    logic suspended;
    logic resume_pulse;
    logic pd_a;
    logic pd_b;
    logic [2:0] cfg_pins;
    logic irq;
    logic [31:0] rd;
    int fails = 0;
    int num_checks = 0;
    int seed = 24;
    int cycles = 0;
    logic [7:0] offs [5] = '{uet_pkg::OFF_EP_TAG_MASK,
        uet_pkg::OFF_OTG_FLAG_MASK, uet_pkg::OFF_POWER_SIGNAL,
        uet_pkg::OFF_IRQ_ENABLE, uet_pkg::OFF_XCVR_CTRL};
    logic [31:0] wmask [5] = '{uet_pkg::WMASK_EP_TAG, 32'hFFFF_FFFF,
        uet_pkg::WMASK_POWER, 32'h0000_0003, uet_pkg::WMASK_XCVR_CTRL};

    uet_top dut (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_wb(wb), .o_wb(wb_rsp),
        .i_rx_ep(rx), .o_rx_ep(rx_tag), .i_line_state(ls),
        .o_line_state_filt(ls_filt), .i_suspend_req(susp_req),
        .i_wake_req(wake_req), .o_suspended(suspended),
        .o_resume_pulse(resume_pulse), .o_eight_bit_port_a_pd_dis(pd_a),
        .o_eight_bit_port_b_pd_dis(pd_b),
        .o_transceiver_config_pins(cfg_pins), .o_irq(irq)
    );
    uet_xcvr_model xm (.i_core_clk(clk), .o_line_state(ls));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Whole run needs under a thousand clocks; far above that means a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            $display("[ERR] %0t run timed out", $time);
            results();
        end
    end

    task automatic results();
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Entered just after a rising edge; leaves one idle cycle behind
    task automatic wb_cycle(input logic we, input logic [7:0] adr,
                            input logic [31:0] d);
        wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: d};
        @(posedge clk);
        // No fixed latency assumed; only the run timeout ends this wait
        while (wb_rsp.ack !== 1'b1) begin
            @(posedge clk);
        end
        rd = wb_rsp.dat;
        wb <= '0;
        @(posedge clk);
    endtask

    task automatic pulse(input logic wake);
        if (wake) begin
            wake_req <= 1'b1;
        end else begin
            susp_req <= 1'b1;
        end
        @(posedge clk);
        wake_req <= 1'b0;
        susp_req <= 1'b0;
        @(posedge clk);
    endtask

    function automatic logic [31:0] ctrl_val(input logic [3:0] n,
                                             input logic auto_on);
        return {20'h0, n, auto_on, 3'h5, 4'h0};
    endfunction

    function automatic logic [4:0] exp_tag(input logic [15:0] m,
                                           input logic [3:0] ep);
        return m[ep] ? {1'b1, ep} : {1'b0, ep};
    endfunction

    task automatic resume_case(input logic [1:0] lsv, input logic [1:0] fl,
                               input int sb, input logic [1:0] en);
        int n;
        wb_cycle(1'b1, uet_pkg::OFF_IRQ_ENABLE, {30'h0, en});
        wb_cycle(1'b1, uet_pkg::OFF_XCVR_CTRL, ctrl_val(4'h1, 1'b1));
        pulse(1'b0);
        @(posedge clk);
        chk(suspended, 1'b1);
        fork xm.hold(lsv, 40); join_none
        n = 0;
        while (resume_pulse !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk(suspended, 1'b0);
        @(posedge clk);
        chk(irq, en[sb]);
        repeat (50) @(posedge clk);
        wb_cycle(1'b0, uet_pkg::OFF_XCVR_CTRL, 32'h0);
        chk(rd[13:12], fl);
        // Writing ones must not disturb a set flag
        wb_cycle(1'b1, uet_pkg::OFF_XCVR_CTRL,
                 ctrl_val(4'h1, 1'b1) | 32'h3000);
        wb_cycle(1'b0, uet_pkg::OFF_XCVR_CTRL, 32'h0);
        chk(rd[13:12], fl);
        wb_cycle(1'b1, uet_pkg::OFF_XCVR_CTRL, ctrl_val(4'h1, 1'b1));
        wb_cycle(1'b0, uet_pkg::OFF_XCVR_CTRL, 32'h0);
        chk(rd[13:12], 2'h0);
        wb_cycle(1'b0, uet_pkg::OFF_IRQ_STATUS, 32'h0);
        chk(rd, 32'h1 << sb);
        wb_cycle(1'b1, uet_pkg::OFF_IRQ_CLEAR, 32'h1 << sb);
        wb_cycle(1'b0, uet_pkg::OFF_IRQ_STATUS, 32'h0);
        chk({rd[1:0], irq}, 3'h0);
    endtask

    initial begin
        int lat;
        logic [15:0] m;
        logic [31:0] d;
        rst_n = 1'b0;
        wb = '0;
        rx = '0;
        susp_req = 1'b0;
        wake_req = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Reset values, including the unmapped word after the block
        for (int i = 0; i < 8; i++) begin
            wb_cycle(1'b0, 8'h34 + 8'(4 * i), 32'h0);
            chk(rd, 32'h0);
        end
        $display("reset values done");
        for (int k = 0; k < 6; k++) begin
            for (int i = 0; i < 5; i++) begin
                d = $random(seed);
                wb_cycle(1'b1, offs[i], d);
                wb_cycle(1'b0, offs[i], 32'h0);
                chk(rd, d & wmask[i]);
            end
            chk({pd_a, pd_b, cfg_pins}, {d[18], d[18], d[6:4]});
        end
        wb_cycle(1'b1, 8'h50, 32'hFFFF_FFFF);
        wb_cycle(1'b0, 8'h50, 32'h0);
        chk(rd, 32'h0);
        $display("register access done");
        for (int j = 0; j < 2; j++) begin
            m = j ? 16'h8001 : 16'($random(seed));
            wb_cycle(1'b1, uet_pkg::OFF_EP_TAG_MASK, {16'h0, m});
            for (int i = 0; i < 16; i++) begin
                rx <= '{valid: 1'b1, ep: 4'(i)};
                @(posedge clk);
                rx.valid <= 1'b0;
                @(posedge clk);
                chk(rx_tag, {1'b1, exp_tag(m, 4'(i))});
            end
        end
        $display("endpoint tagging done");
        for (int n = 0; n < 4; n++) begin
            wb_cycle(1'b1, uet_pkg::OFF_XCVR_CTRL, ctrl_val(4'(n), 1'b0));
            fork xm.hold(uet_pkg::LS_K, 40); join_none
            lat = 0;
            while (ls_filt !== uet_pkg::LS_K && lat < 200) begin
                @(posedge clk);
                lat++;
            end
            // Model launch, three sync flops, agree flop, filter capture,
            // output flop: eight clocks around the filter's own 2^n
            chk(lat, 8 + (1 << n));
            repeat (60) @(posedge clk);
        end
        // Glitch shorter than the eight-clock window must vanish
        fork xm.hold(uet_pkg::LS_K, 4); join_none
        lat = 0;
        repeat (30) begin
            @(posedge clk);
            if (ls_filt === uet_pkg::LS_K) begin
                lat++;
            end
        end
        chk(lat, 0);
        $display("line filter done");
        resume_case(uet_pkg::LS_SE0, 2'h2, 0, 2'h3);
        resume_case(uet_pkg::LS_K, 2'h1, 1, 2'h1);
        $display("auto resume done");
        wb_cycle(1'b1, uet_pkg::OFF_XCVR_CTRL, ctrl_val(4'h0, 1'b0));
        pulse(1'b0);
        fork xm.hold(uet_pkg::LS_SE0, 20); join_none
        lat = 0;
        while (ls_filt !== uet_pkg::LS_SE0 && lat < 100) begin
            @(posedge clk);
            lat++;
        end
        chk(ls_filt, uet_pkg::LS_SE0);
        repeat (30) @(posedge clk);
        chk(suspended, 1'b1);
        wb_cycle(1'b0, uet_pkg::OFF_XCVR_CTRL, 32'h0);
        chk(rd[13:12], 2'h0);
        // The resume pulse stands for one cycle, seen as pulse returns
        pulse(1'b1);
        chk({suspended, resume_pulse}, 2'b01);
        $display("manual wake done");
        results();
    end
endmodule // uet_top_bench
